// *** core/rce_executor.sv ***
`timescale 1ns/100ps
`default_nettype none
module rce_executor (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  // remote write words
  input wire logic [15:0] command_code_word,
  input wire logic [15:0] target_address_word,
  input wire logic [15:0] setting_value_low,
  input wire logic [15:0] setting_value_high,
  input wire logic cmd_request,
  // command decoder and local conditions
  output logic [15:0] exec_code,
  input wire logic [1:0] exec_class,
  input wire logic tool_port_busy,
  input wire logic nvm_busy,
  input wire logic [11:0] node_enabled,
  // execution engine handshake
  output logic exec_start,
  output logic [15:0] exec_addr,
  output logic [31:0] exec_value,
  input wire logic exec_done,
  input wire rce_pkg::rce_result_t exec_result,
  // remote read words and flags
  output logic [15:0] response_code_word,
  output logic [15:0] response_address_word,
  output logic [15:0] response_data_low,
  output logic [15:0] response_data_high,
  output logic internal_busy_flag,
  output logic cmd_done,
  output logic reg_error,
  output logic [7:0] comm_error_code
);
  ////////////////////////////////////////////////////////////////////////////
  // request flag sampling and edge detect
  logic req_d;
  logic req_rise;
  logic req_fall;
  rce_pkg::rce_state_t state;
  rce_pkg::rce_req_t req;
  rce_pkg::rce_class_t cls;
  logic [7:0] pre_err;
  logic [7:0] post_err;

  assign req_rise = cmd_request & ~req_d;
  assign req_fall = ~cmd_request & req_d;
  assign cls = rce_pkg::rce_class_t'(exec_class);

  // address is legal if it names this converter or an enabled node
  function automatic logic addr_ok(input logic [15:0] a, input logic [11:0] en);
    if (a == rce_pkg::ADDR_SELF) begin
      return 1'b1;
    end
    if (a > rce_pkg::ADDR_MAX) begin
      return 1'b0;
    end
    return en[a[3:0]];
  endfunction : addr_ok

  // request flag comes from logic on this clock, no synchroniser needed
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      req_d <= 1'b0;
    end else if (clk_en) begin
      req_d <= cmd_request;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // refusal checks made before launching; priority goes to the undefined code, then local blockers
  always_comb begin
    pre_err = rce_pkg::ERR_NONE;
    if (cls == rce_pkg::RCE_CLS_UNDEF) begin
      pre_err = rce_pkg::ERR_UNDEF;
    end else if (tool_port_busy) begin
      pre_err = rce_pkg::ERR_TOOL;
    end else if (nvm_busy) begin
      pre_err = rce_pkg::ERR_NVM;
    end else if (!addr_ok(req.addr, node_enabled)) begin
      pre_err = rce_pkg::ERR_TIMEOUT;
    end
  end

  // errors reported by the engine after running
  always_comb begin
    post_err = rce_pkg::ERR_NONE;
    if (exec_result.link_err) begin
      post_err = rce_pkg::ERR_LINK;
    end else if (exec_result.timeout) begin
      post_err = rce_pkg::ERR_TIMEOUT;
    end else if (exec_result.remote_err) begin
      post_err = rce_pkg::ERR_REMOTE;
    end else if (exec_result.range_err) begin
      post_err = rce_pkg::ERR_RANGE;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // latch request words on the rising edge only
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      req <= '0;
    end else if (clk_en && state == rce_pkg::RCE_IDLE && req_rise) begin
      req.code <= command_code_word;
      req.addr <= target_address_word;
      req.value <= {setting_value_high, setting_value_low};
    end
  end

  assign exec_code = req.code;

  ////////////////////////////////////////////////////////////////////////////
  // sequencer: idle, one-cycle check then execute, hold until request drops
  logic checking;
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      state <= rce_pkg::RCE_IDLE;
      checking <= 1'b0;
      exec_start <= 1'b0;
      internal_busy_flag <= 1'b0;
    end else if (clk_en) begin
      exec_start <= 1'b0;
      case (state)
        rce_pkg::RCE_IDLE: begin
          if (req_rise) begin
            state <= rce_pkg::RCE_EXEC;
            checking <= 1'b1;
            internal_busy_flag <= 1'b1;
          end
        end
        rce_pkg::RCE_EXEC: begin
          if (checking) begin
            checking <= 1'b0;
            if (pre_err != rce_pkg::ERR_NONE) begin
              state <= rce_pkg::RCE_HOLD;
              internal_busy_flag <= 1'b0;
            end else begin
              exec_start <= 1'b1;
            end
          end else if (exec_done) begin
            state <= rce_pkg::RCE_HOLD;
            internal_busy_flag <= 1'b0;
          end
        end
        rce_pkg::RCE_HOLD: begin
          if (!cmd_request) begin
            state <= rce_pkg::RCE_IDLE;
          end
        end
        default: begin
          state <= rce_pkg::RCE_IDLE;
          checking <= 1'b0;
          internal_busy_flag <= 1'b0;
        end
      endcase
    end
  end

  // engine sees the latched words, stable for the whole execution
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      exec_addr <= rce_pkg::WORD_RESET;
      exec_value <= '0;
    end else if (clk_en && checking) begin
      exec_addr <= req.addr;
      // maintenance value passed unchanged; master supplies one
      exec_value <= req.value;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // completion: response words, flags and error code
  logic fin_ok;
  logic fin_bad;
  logic [31:0] good_data;
  assign fin_bad = (state == rce_pkg::RCE_EXEC) && ((checking && pre_err != rce_pkg::ERR_NONE)
                   || (!checking && exec_done && post_err != rce_pkg::ERR_NONE));
  assign fin_ok = (state == rce_pkg::RCE_EXEC) && !checking && exec_done
                  && post_err == rce_pkg::ERR_NONE;
  assign good_data = (cls == rce_pkg::RCE_CLS_READ) ? exec_result.data : req.value;

  always_ff @(posedge clock) begin
    if (sys_rst) begin
      response_code_word <= rce_pkg::WORD_RESET;
      response_address_word <= rce_pkg::WORD_RESET;
      response_data_low <= rce_pkg::WORD_RESET;
      response_data_high <= rce_pkg::WORD_RESET;
    end else if (clk_en && (fin_ok || fin_bad)) begin
      response_code_word <= req.code;
      response_code_word[rce_pkg::ERR_BIT] <= fin_bad;
      response_address_word <= req.addr;
      // failed command returns zero data
      response_data_low <= fin_ok ? good_data[15:0] : rce_pkg::WORD_RESET;
      response_data_high <= fin_ok ? good_data[31:16] : rce_pkg::WORD_RESET;
    end
  end

  // done and error flags; a drop of the request clears both
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      cmd_done <= 1'b0;
      reg_error <= 1'b0;
    end else if (clk_en) begin
      if (fin_ok) begin
        cmd_done <= 1'b1;
      end else if (req_fall || !cmd_request) begin
        cmd_done <= 1'b0;
      end
      if (fin_bad) begin
        reg_error <= 1'b1;
      end else if (!cmd_request) begin
        reg_error <= 1'b0;
      end
    end
  end

  // last communication error code, read by the monitor path
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      comm_error_code <= rce_pkg::ERR_NONE;
    end else if (clk_en) begin
      if (fin_ok) begin
        comm_error_code <= rce_pkg::ERR_NONE;
      end else if (fin_bad) begin
        comm_error_code <= checking ? pre_err : post_err;
      end
    end
  end
endmodule : rce_executor
`default_nettype wire

// *** shared/rce_pkg.sv ***
// Behaviour
// - address 0 to 11 selects a downstream node, 80h selects this converter
// - write commands use the 32-bit setting value, low word first; reads ignore it
// - execution starts when the request flag rises with valid request words
// - command code and address are echoed into the first two response words
// - read commands return the 32-bit result, low half then high half
// - write and maintenance commands echo the setting value as response data
// - response code bit 15 is set on failure, cleared on success
// - internal busy flag stays high throughout command execution
// - done flag rises after proper completion
// - master drops request after completion; device then drops done
// - on error: skip command, clear busy, raise error flag, never done
// - error flag clears when the master drops the request flag
// - last error code kept readable; cleared to 00h after a good command
// - downstream hardware, check character or header error reports 84h
// - downstream timeout or disabled node connection reports 85h
// - undefined command code reports 88h and is refused
// - busy operator tool port reports 89h and refuses the command
// - non-volatile memory operation in progress reports 8Ah and refuses
// - setting data out of range reports 8Ch
// - downstream node returning an error reports 8Dh
package rce_pkg;
  // remote word offsets, same for write and read sides
  localparam logic [3:0] OFS_CODE = 4'hC;
  localparam logic [3:0] OFS_ADDR = 4'hD;
  localparam logic [3:0] OFS_DLOW = 4'hE;
  localparam logic [3:0] OFS_DHIGH = 4'hF;
  localparam int ERR_BIT = 15;
  localparam logic [15:0] ADDR_SELF = 16'h0080;
  localparam logic [15:0] ADDR_MAX = 16'h000B;
  localparam logic [15:0] WORD_RESET = 16'h0000;
  // communication error codes
  localparam logic [7:0] ERR_NONE = 8'h00;
  localparam logic [7:0] ERR_LINK = 8'h84;
  localparam logic [7:0] ERR_TIMEOUT = 8'h85;
  localparam logic [7:0] ERR_UNDEF = 8'h88;
  localparam logic [7:0] ERR_TOOL = 8'h89;
  localparam logic [7:0] ERR_NVM = 8'h8A;
  localparam logic [7:0] ERR_RANGE = 8'h8C;
  localparam logic [7:0] ERR_REMOTE = 8'h8D;

  // command classes from the command decoder
  typedef enum logic [1:0] {
    RCE_CLS_READ = 2'h0,
    RCE_CLS_WRITE = 2'h1,
    RCE_CLS_MAINT = 2'h2,
    RCE_CLS_UNDEF = 2'h3
  } rce_class_t;

  typedef enum logic [2:0] {
    RCE_IDLE = 3'b001,
    RCE_EXEC = 3'b010,
    RCE_HOLD = 3'b100
  } rce_state_t;

  // latched request words
  typedef struct packed {
    logic [15:0] code;
    logic [15:0] addr;
    logic [31:0] value;
  } rce_req_t;

  // completion report from the execution engine
  typedef struct packed {
    logic link_err;
    logic timeout;
    logic remote_err;
    logic range_err;
    logic [31:0] data;
  } rce_result_t;
endpackage : rce_pkg

// *** dv/rce_executor_checker.sv ***
`timescale 1ns/100ps
`default_nettype none
module rce_executor_checker (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic clk_en,
  input wire logic [15:0] command_code_word,
  input wire logic [15:0] target_address_word,
  input wire logic cmd_request,
  input wire logic exec_start,
  input wire logic exec_done,
  input wire rce_pkg::rce_result_t exec_result,
  input wire logic [15:0] response_code_word,
  input wire logic [15:0] response_address_word,
  input wire logic internal_busy_flag,
  input wire logic cmd_done,
  input wire logic reg_error,
  input wire logic [7:0] comm_error_code
);
  default clocking @(posedge clock); endclocking
  // a frozen design cannot answer, so checks pause while the enable is low
  default disable iff (sys_rst || !clk_en);
  logic req_q;
  logic idle;
  logic fail;
  logic [15:0] code_q;
  logic [15:0] addr_q;
  assign idle = !internal_busy_flag && !cmd_done && !reg_error;
  assign fail = |exec_result[35:32];
  // words as they stood on the taken edge, for the echo check
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      req_q <= 1'b0;
    end else if (clk_en) begin
      req_q <= cmd_request;
    end
    if (!sys_rst && clk_en && cmd_request && !req_q && idle) begin
      code_q <= command_code_word;
      addr_q <= target_address_word;
    end
  end
  sequence s_take;
    cmd_request && !req_q && idle;
  endsequence
  sequence s_finish;
    internal_busy_flag && exec_done;
  endsequence
  ////////////////////////////////////////////////////////////////////
  AST_BUSY_RISE: assert property (s_take |=> internal_busy_flag)
    else $error("busy did not rise after request");
  AST_START: assert property ($rose(internal_busy_flag) |=>
    (exec_start && internal_busy_flag) || (reg_error && !internal_busy_flag))
    else $error("neither start nor refusal");
  AST_BUSY_HOLD: assert property (internal_busy_flag &&
    !$rose(internal_busy_flag) && !exec_done |=> internal_busy_flag)
    else $error("busy dropped early");
  AST_DONE_OK: assert property (s_finish ##0 !fail |=> cmd_done && !reg_error)
    else $error("done missing after good finish");
  AST_ERR_END: assert property (s_finish ##0 fail |=>
    reg_error && !cmd_done && !internal_busy_flag)
    else $error("error flag missing after failure");
  AST_DONE_CLEAR: assert property (cmd_done && !cmd_request |=> !cmd_done)
    else $error("done not cleared");
  AST_ERR_CLEAR: assert property (reg_error && !cmd_request |=> !reg_error)
    else $error("error flag not cleared");
  AST_ECHO: assert property ($rose(cmd_done) || $rose(reg_error) |->
    response_address_word == addr_q && response_code_word == {reg_error, code_q[14:0]})
    else $error("echo words wrong");
  AST_CODE_OK: assert property ($rose(cmd_done) |-> comm_error_code == 8'h00)
    else $error("error code not cleared");
endmodule : rce_executor_checker
bind rce_executor rce_executor_checker rce_executor_checker_i (.clock(clock),
  .sys_rst(sys_rst), .clk_en(clk_en), .command_code_word(command_code_word),
  .target_address_word(target_address_word), .cmd_request(cmd_request),
  .exec_start(exec_start), .exec_done(exec_done), .exec_result(exec_result),
  .response_code_word(response_code_word), .response_address_word(response_address_word),
  .internal_busy_flag(internal_busy_flag), .cmd_done(cmd_done), .reg_error(reg_error),
  .comm_error_code(comm_error_code));
`default_nettype wire

// *** dv/rce_engine_model.sv ***
`timescale 1ns/100ps
`default_nettype none
module rce_engine_model (
  input wire logic clock,
  input wire logic sys_rst,
  input wire logic [15:0] exec_code,
  output logic [1:0] exec_class,
  input wire logic exec_start,
  input wire logic [15:0] exec_addr,
  input wire logic [31:0] exec_value,
  output logic exec_done,
  output rce_pkg::rce_result_t exec_result,
  input wire logic [3:0] err_sel,
  input wire logic [7:0] lat
);
  logic run;
  logic [7:0] cnt;
  // decoder: class sits in code bits 9:8
  assign exec_class = exec_code[9:8];
  // engine answers lat cycles after start, lat at least one
  always_ff @(posedge clock) begin
    exec_done <= 1'b0;
    if (sys_rst) begin
      run <= 1'b0;
    end else if (exec_start) begin
      run <= 1'b1;
      cnt <= lat;
    end else if (run && cnt <= 8'h01) begin
      run <= 1'b0;
      exec_done <= 1'b1;
    end else if (run) begin
      cnt <= cnt - 8'h01;
    end
  end
  // reads ignore the value; garbage outside done
  assign exec_result = exec_done ? rce_pkg::rce_result_t'({err_sel, (exec_class == 2'h0) ?
    {16'h5A00, exec_addr} : exec_value}) : rce_pkg::rce_result_t'({4'hA, ~exec_value});
endmodule : rce_engine_model
`default_nettype wire

// *** dv/remote_command_executor_tb.sv ***
`timescale 1ns/100ps
`default_nettype none
module remote_command_executor_tb;
  typedef struct packed {
    logic [15:0] code, addr; logic [31:0] val; logic [3:0] err; logic tool, nvm;
    logic [15:0] rc; logic [31:0] data; logic [7:0] ec;
  } rce_row_t;
  logic clock, sys_rst, clk_en, req, tool, nvm, start, done_p, busy, cmd_done, reg_error;
  logic [15:0] code_w, addr_w, ex_code, ex_addr, r_code, r_addr, r_lo, r_hi;
  logic [31:0] val_w, ex_val;
  logic [11:0] node_en;
  logic [7:0] lat, ecode;
  logic [3:0] err_sel;
  logic [1:0] ex_class;
  rce_pkg::rce_result_t ex_res;
  rce_row_t rows [14];
  int fails, total_checks, cycles;
  ////////////////////////////////////////////////////////////////////
  rce_executor rce_executor_i (.clock(clock), .sys_rst(sys_rst), .clk_en(clk_en),
    .command_code_word(code_w), .target_address_word(addr_w),
    .setting_value_low(val_w[15:0]), .setting_value_high(val_w[31:16]), .cmd_request(req),
    .exec_code(ex_code), .exec_class(ex_class), .tool_port_busy(tool), .nvm_busy(nvm),
    .node_enabled(node_en), .exec_start(start), .exec_addr(ex_addr), .exec_value(ex_val),
    .exec_done(done_p), .exec_result(ex_res), .response_code_word(r_code),
    .response_address_word(r_addr), .response_data_low(r_lo), .response_data_high(r_hi),
    .internal_busy_flag(busy), .cmd_done(cmd_done), .reg_error(reg_error),
    .comm_error_code(ecode));
  rce_engine_model rce_engine_model_i (.clock(clock), .sys_rst(sys_rst), .exec_code(ex_code),
    .exec_class(ex_class), .exec_start(start), .exec_addr(ex_addr), .exec_value(ex_val),
    .exec_done(done_p), .exec_result(ex_res), .err_sel(err_sel), .lat(lat));
  ////////////////////////////////////////////////////////////////////
  task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      fails++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check
  task automatic finish_test();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : finish_test
  // one transfer; words set before the request rises
  task automatic run_row(input rce_row_t r);
    int n;
    {code_w, addr_w, val_w, err_sel, tool, nvm} = {r.code, r.addr, r.val, r.err, r.tool, r.nvm};
    @(negedge clock) req = 1'b1;
    n = 0;
    while (cmd_done !== 1'b1 && reg_error !== 1'b1 && n < 300) begin
      @(negedge clock);
      n++;
    end
    check("resp_code", 32'(r_code), 32'(r.rc));
    check("resp_addr", 32'(r_addr), 32'(r.addr));
    check("resp_data", {r_hi, r_lo}, r.data);
    check("err_code", 32'(ecode), 32'(r.ec));
    check("flags", 32'({cmd_done, reg_error}), 32'((r.ec == 8'h00) ? 2'b10 : 2'b01));
    req = 1'b0;
    repeat (2) @(negedge clock);
    check("flags_off", 32'({cmd_done, reg_error, busy}), 32'h0);
  endtask : run_row
  ////////////////////////////////////////////////////////////////////
  // free-running clock and hang guard
  initial begin
    clock = 1'b0;
    forever #4 clock = ~clock;
  end
  always @(posedge clock) begin
    cycles++;
    if (cycles == 5000) begin
      fails++;
      finish_test();
    end
  end
  // rows: cases
  initial begin
    rows = '{'{16'h0010, 16'h3, 32'h11112222, 4'h0, 1'b0, 1'b0, 16'h0010, 32'h5A000003, 8'h00},
      '{16'h0120, 16'h80, 32'hDEAD0001, 4'h0, 1'b0, 1'b0, 16'h0120, 32'hDEAD0001, 8'h00},
      '{16'h0230, 16'hB, 32'h1, 4'h0, 1'b0, 1'b0, 16'h0230, 32'h1, 8'h00},
      '{16'h0340, 16'h3, 32'h5, 4'h0, 1'b0, 1'b0, 16'h8340, 32'h0, 8'h88},
      '{16'h0120, 16'h3, 32'h5, 4'h0, 1'b1, 1'b0, 16'h8120, 32'h0, 8'h89},
      '{16'h0120, 16'h3, 32'h5, 4'h0, 1'b0, 1'b1, 16'h8120, 32'h0, 8'h8A},
      '{16'h0120, 16'hC, 32'h5, 4'h0, 1'b0, 1'b0, 16'h8120, 32'h0, 8'h85},
      '{16'h0120, 16'h7, 32'h5, 4'h0, 1'b0, 1'b0, 16'h8120, 32'h0, 8'h85},
      '{16'h0010, 16'h2, 32'h5, 4'h8, 1'b0, 1'b0, 16'h8010, 32'h0, 8'h84},
      '{16'h0010, 16'h2, 32'h5, 4'h4, 1'b0, 1'b0, 16'h8010, 32'h0, 8'h85},
      '{16'h0120, 16'h2, 32'h5, 4'h2, 1'b0, 1'b0, 16'h8120, 32'h0, 8'h8D},
      '{16'h0120, 16'h2, 32'h5, 4'h1, 1'b0, 1'b0, 16'h8120, 32'h0, 8'h8C},
      '{16'h0120, 16'h2, 32'h5, 4'hF, 1'b0, 1'b0, 16'h8120, 32'h0, 8'h84},
      '{16'h0120, 16'h0, 32'h7, 4'h0, 1'b0, 1'b0, 16'h0120, 32'h7, 8'h00}};
    {sys_rst, req, tool, nvm, code_w, addr_w, val_w, err_sel} = {1'b1, 67'h0};
    node_en = 12'hF7F;
    clk_en = 1'b1;
    lat = 8'h01;
    repeat (10) @(negedge clock);
    sys_rst = 1'b0;
    check("reset_out", 32'({busy, cmd_done, reg_error, start, ecode, r_code}), 32'h0);
    for (int i = 0; i < 14; i++) begin
      lat = 8'(i % 4 * 6 + 1);
      run_row(rows[i]);
    end
    // change after the taken edge must not leak or relaunch
    {code_w, addr_w, val_w, lat} = {16'h0120, 16'h4, 32'hBEEF, 8'h05};
    clk_en = 1'b0;
    req = 1'b1;
    repeat (3) @(negedge clock);
    check("frozen", 32'(busy), 32'h0);
    clk_en = 1'b1;
    repeat (2) @(negedge clock);
    addr_w = 16'h1;
    repeat (14) @(negedge clock);
    check("latched", 32'(r_addr), 32'h4);
    check("one_run", 32'({busy, cmd_done}), 32'h1);
    check("eng_addr", 32'(ex_addr), 32'h4);
    check("eng_value", ex_val, 32'h0000BEEF);
    check("write_echo", {r_hi, r_lo}, 32'h0000BEEF);
    req = 1'b0;
    repeat (2) @(negedge clock);
    finish_test();
  end
endmodule : remote_command_executor_tb
`default_nettype wire
